// ===== common/fault_map.svh
// register offsets, field positions and reset values of the fault unit
//
// Contract
// - vector read bus error sets hard fault flag
// - escalated fault sets escalation flag
// - protection mismatch sets memory management flags
// - execute-never fetch always flags instruction violation
// - bus error flags stacking, unstacking, prefetch, lazy
// - data bus error flags exact or inexact
// - usage fault flags coprocessor, undefined, state, return
// - unaligned and divide by zero own flags
// - invalid state on foreign set or continuation
// - lazy fp flags only with fpu
// - configurable priority and enable except hard fault
// - same fault in own handler escalates
// - fault at or below current priority escalates
// - disabled handler fault escalates
// - bus stacking fault entering bus handler never escalates
// - hard fault preempts all but reset, nmi
// - capture address for bus and memory faults
// - hard fault in nmi or hard handler locks
// - leave lockup by reset, nmi or halt
// - nmi cannot release lockup entered from nmi
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define HF_STATUS_ADDR   12'h000
`define MM_STATUS_ADDR   12'h004
`define MM_ADDRESS_ADDR  12'h008
`define BUS_STATUS_ADDR  12'h00c
`define BUS_ADDRESS_ADDR 12'h010
`define USE_STATUS_ADDR  12'h014
`define CONTROL_ADDR     12'h018
`define PRIORITY_ADDR    12'h01c
`define LOCK_STATE_ADDR  12'h020
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define HF_VECTOR_BIT    1
`define HF_FORCED_BIT    30
`define MM_INSTR_BIT     0
`define MM_DATA_BIT      1
`define MM_UNSTACK_BIT   3
`define MM_STACK_BIT     4
`define MM_LAZY_BIT      5
`define BUS_PREFETCH_BIT 0
`define BUS_EXACT_BIT    1
`define BUS_INEXACT_BIT  2
`define BUS_UNSTACK_BIT  3
`define BUS_STACK_BIT    4
`define BUS_LAZY_BIT     5
`define USE_UNDEF_BIT    0
`define USE_STATE_BIT    1
`define USE_RETURN_BIT   2
`define USE_COPROC_BIT   3
`define USE_UNALIGN_BIT  8
`define USE_DIVZERO_BIT  9
`define CTRL_MM_EN_BIT   0
`define CTRL_BUS_EN_BIT  1
`define CTRL_USE_EN_BIT  2
`define PRIO_MM_LSB      0
`define PRIO_BUS_LSB     8
`define PRIO_USE_LSB     16
`define LOCK_BIT         0
`define LOCK_NMI_BIT     1
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CONTROL_RESET    3'h0
`define PRIORITY_RESET   8'h00
`define WORD_ZERO        32'h0000_0000
`endif

// ===== common/fault_pkg.sv
// types carried between the fault unit and its neighbours
package fault_pkg;
  typedef enum logic [1:0] {
    cls_mem,
    cls_bus,
    cls_use,
    cls_hard
  } fault_class_type;

  typedef struct packed {
    logic        instr_access;
    logic        xn_fetch;
    logic        data_access;
    logic        mm_stacking;
    logic        mm_unstacking;
    logic        mm_lazy_fp;
    logic        bus_stacking;
    logic        bus_unstacking;
    logic        prefetch;
    logic        bus_lazy_fp;
    logic        data_bus_exact;
    logic        data_bus_inexact;
    logic        vector_read;
    logic        coprocessor;
    logic        undefined;
    logic        foreign_set;
    logic        continuation_return;
    logic        bad_return_code;
    logic        unaligned;
    logic        divide_zero;
    logic        entering_bus_handler;
    logic [31:0] address;
  } fault_event_type;

  typedef struct packed {
    logic       in_handler;
    logic [7:0] exec_priority;
    logic       servicing_mem;
    logic       servicing_bus;
    logic       servicing_use;
    logic       in_nmi;
    logic       in_hard;
  } exec_state_type;

  typedef struct packed {
    logic            take;
    fault_class_type cls;
    logic            escalated;
  } fault_report_type;
endpackage

// ===== rtl/fault_unit.sv
// fault classification, escalation and lockup with an apb register view
`timescale 1ns/100ps
`include "fault_map.svh"
module fault_unit #(
  parameter bit HAS_FPU = 1'b1
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire fault_pkg::fault_event_type  fault_in,
  input  wire fault_pkg::exec_state_type   exec_in,
  input  wire logic                        nmi,
  input  wire logic                        debug_halt,
  output fault_pkg::fault_report_type      report,
  output logic                             lockup
);
  import fault_pkg::*;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] hf_q, mm_q, bus_q, use_q, mm_addr_q, bus_addr_q;
  logic [31:0] hf_d, mm_d, bus_d, use_d;
  logic [2:0]  ctrl_q;
  logic [7:0]  prio_mm_q, prio_bus_q, prio_use_q;
  logic        lock_q, lock_nmi_q, lock_d, lock_nmi_d;
  fault_report_type report_d;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire acc       = psel & penable;
  wire wr        = acc & pwrite;
  wire hit_hf    = paddr == `HF_STATUS_ADDR;
  wire hit_mm    = paddr == `MM_STATUS_ADDR;
  wire hit_mma   = paddr == `MM_ADDRESS_ADDR;
  wire hit_bus   = paddr == `BUS_STATUS_ADDR;
  wire hit_busa  = paddr == `BUS_ADDRESS_ADDR;
  wire hit_use   = paddr == `USE_STATUS_ADDR;
  wire hit_ctrl  = paddr == `CONTROL_ADDR;
  wire hit_prio  = paddr == `PRIORITY_ADDR;
  wire hit_lock  = paddr == `LOCK_STATE_ADDR;
  wire mapped    = hit_hf | hit_mm | hit_mma | hit_bus | hit_busa | hit_use
                 | hit_ctrl | hit_prio | hit_lock;
  wire [31:0] w1c_hf  = (wr & hit_hf)  ? pwdata : `WORD_ZERO;
  wire [31:0] w1c_mm  = (wr & hit_mm)  ? pwdata : `WORD_ZERO;
  wire [31:0] w1c_bus = (wr & hit_bus) ? pwdata : `WORD_ZERO;
  wire [31:0] w1c_use = (wr & hit_use) ? pwdata : `WORD_ZERO;
  wire [31:0] prio_word = {8'h00, prio_use_q, prio_bus_q, prio_mm_q};
  wire [31:0] lock_word = {30'h0, lock_nmi_q, lock_q};
  wire [31:0] rd_mux =
      hit_hf   ? hf_q       : hit_mm   ? mm_q       : hit_mma ? mm_addr_q :
      hit_bus  ? bus_q      : hit_busa ? bus_addr_q : hit_use ? use_q     :
      hit_ctrl ? {29'h0, ctrl_q} : hit_prio ? prio_word :
      hit_lock ? lock_word  : `WORD_ZERO;

  // ------------------------------------------------------------
  // classification
  // ------------------------------------------------------------
  wire lazy_ok = HAS_FPU;
  wire ev_iacc = fault_in.instr_access | fault_in.xn_fetch;
  wire ev_mm   = ev_iacc | fault_in.data_access | fault_in.mm_stacking
               | fault_in.mm_unstacking | (fault_in.mm_lazy_fp & lazy_ok);
  wire ev_bus  = fault_in.bus_stacking | fault_in.bus_unstacking
               | fault_in.prefetch | (fault_in.bus_lazy_fp & lazy_ok)
               | fault_in.data_bus_exact | fault_in.data_bus_inexact;
  wire ev_state = fault_in.foreign_set | fault_in.continuation_return;
  wire ev_use  = fault_in.coprocessor | fault_in.undefined | ev_state
               | fault_in.bad_return_code | fault_in.unaligned | fault_in.divide_zero;
  wire ev_vec  = fault_in.vector_read;

  // memory faults take precedence over bus, bus over usage, one class per cycle
  wire sel_mm  = ev_mm;
  wire sel_bus = ~ev_mm & ev_bus;
  wire sel_use = ~ev_mm & ~ev_bus & ev_use;
  wire [7:0] sel_prio = sel_mm ? prio_mm_q : sel_bus ? prio_bus_q : prio_use_q;
  wire sel_en  = sel_mm ? ctrl_q[`CTRL_MM_EN_BIT] :
                 sel_bus ? ctrl_q[`CTRL_BUS_EN_BIT] : ctrl_q[`CTRL_USE_EN_BIT];
  wire same_kind = (sel_mm & exec_in.servicing_mem) | (sel_bus & exec_in.servicing_bus)
                 | (sel_use & exec_in.servicing_use);
  // lower number is higher priority
  wire not_above = exec_in.in_handler & (sel_prio >= exec_in.exec_priority);
  wire stack_exempt = sel_bus & fault_in.bus_stacking & fault_in.entering_bus_handler;
  wire cfg_fault = sel_mm | sel_bus | sel_use;
  wire escalate = cfg_fault & ~stack_exempt
                & (same_kind | not_above | ~sel_en);
  wire hard_now = ev_vec | escalate;
  wire any_fault = cfg_fault | ev_vec;
  wire lock_entry = hard_now & (exec_in.in_nmi | exec_in.in_hard);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    hf_d  = hf_q  & ~w1c_hf;
    mm_d  = mm_q  & ~w1c_mm;
    bus_d = bus_q & ~w1c_bus;
    use_d = use_q & ~w1c_use;
    // set wins over a clear in the same cycle
    if (ev_vec) hf_d[`HF_VECTOR_BIT] = 1'b1;
    if (escalate) hf_d[`HF_FORCED_BIT] = 1'b1;
    if (ev_iacc) mm_d[`MM_INSTR_BIT] = 1'b1;
    if (fault_in.data_access) mm_d[`MM_DATA_BIT] = 1'b1;
    if (fault_in.mm_stacking) mm_d[`MM_STACK_BIT] = 1'b1;
    if (fault_in.mm_unstacking) mm_d[`MM_UNSTACK_BIT] = 1'b1;
    if (fault_in.mm_lazy_fp & lazy_ok) mm_d[`MM_LAZY_BIT] = 1'b1;
    if (fault_in.bus_stacking) bus_d[`BUS_STACK_BIT] = 1'b1;
    if (fault_in.bus_unstacking) bus_d[`BUS_UNSTACK_BIT] = 1'b1;
    if (fault_in.prefetch) bus_d[`BUS_PREFETCH_BIT] = 1'b1;
    if (fault_in.bus_lazy_fp & lazy_ok) bus_d[`BUS_LAZY_BIT] = 1'b1;
    if (fault_in.data_bus_exact) bus_d[`BUS_EXACT_BIT] = 1'b1;
    if (fault_in.data_bus_inexact) bus_d[`BUS_INEXACT_BIT] = 1'b1;
    if (fault_in.coprocessor) use_d[`USE_COPROC_BIT] = 1'b1;
    if (fault_in.undefined) use_d[`USE_UNDEF_BIT] = 1'b1;
    if (ev_state) use_d[`USE_STATE_BIT] = 1'b1;
    if (fault_in.bad_return_code) use_d[`USE_RETURN_BIT] = 1'b1;
    if (fault_in.unaligned) use_d[`USE_UNALIGN_BIT] = 1'b1;
    if (fault_in.divide_zero) use_d[`USE_DIVZERO_BIT] = 1'b1;
  end

  // lockup: nmi releases only when lockup did not start in the nmi handler
  always_comb begin
    lock_d     = lock_q;
    lock_nmi_d = lock_nmi_q;
    if (lock_q & (debug_halt | (nmi & ~lock_nmi_q))) begin
      lock_d     = 1'b0;
      lock_nmi_d = 1'b0;
    end else if (~lock_q & lock_entry) begin
      lock_d     = 1'b1;
      lock_nmi_d = exec_in.in_nmi;
    end
  end

  // hard fault outranks every configurable class; priority logic reports nothing while locked
  always_comb begin
    report_d.take      = any_fault & ~lock_d;
    report_d.cls       = hard_now ? cls_hard : sel_mm ? cls_mem : sel_bus ? cls_bus : cls_use;
    report_d.escalated = escalate;
  end

  // ------------------------------------------------------------
  // flops
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_q  <= `WORD_ZERO;
      mm_q  <= `WORD_ZERO;
      bus_q <= `WORD_ZERO;
      use_q <= `WORD_ZERO;
      lock_q     <= 1'b0;
      lock_nmi_q <= 1'b0;
      report     <= '0;
      lockup     <= 1'b0;
    end else begin
      hf_q  <= hf_d;
      mm_q  <= mm_d;
      bus_q <= bus_d;
      use_q <= use_d;
      lock_q     <= lock_d;
      lock_nmi_q <= lock_nmi_d;
      report     <= report_d;
      lockup     <= lock_d;
    end
  end

  // addresses follow the newest data, stacking or unstacking fault of their class, bus data faults only when exact
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mm_addr_q  <= `WORD_ZERO;
      bus_addr_q <= `WORD_ZERO;
    end else begin
      if (fault_in.data_access | fault_in.mm_stacking | fault_in.mm_unstacking)
        mm_addr_q <= fault_in.address;
      if (fault_in.data_bus_exact | fault_in.bus_stacking | fault_in.bus_unstacking)
        bus_addr_q <= fault_in.address;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `CONTROL_RESET;
      prio_mm_q  <= `PRIORITY_RESET;
      prio_bus_q <= `PRIORITY_RESET;
      prio_use_q <= `PRIORITY_RESET;
    end else if (wr & hit_ctrl) begin
      ctrl_q <= pwdata[2:0];
    end else if (wr & hit_prio) begin
      prio_mm_q  <= pwdata[`PRIO_MM_LSB +: 8];
      prio_bus_q <= pwdata[`PRIO_BUS_LSB +: 8];
      prio_use_q <= pwdata[`PRIO_USE_LSB +: 8];
    end
  end

  // zero wait states keep the read path a single register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `WORD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : `WORD_ZERO;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  vector_flag_a: assert property (ev_vec |=> hf_q[`HF_VECTOR_BIT] && report.cls == cls_hard)
    else $error("vector read fault not recorded");
  forced_flag_a: assert property (escalate |=> hf_q[`HF_FORCED_BIT])
    else $error("escalation flag missing");
  xn_fetch_a: assert property (fault_in.xn_fetch |=> mm_q[`MM_INSTR_BIT])
    else $error("execute never fetch not flagged");
  exact_flag_a: assert property (fault_in.data_bus_exact |=> bus_q[`BUS_EXACT_BIT])
    else $error("exact bus flag missing");
  divzero_flag_a: assert property (fault_in.divide_zero |=> use_q[`USE_DIVZERO_BIT])
    else $error("divide flag missing");
  disabled_esc_a: assert property (sel_use && !ctrl_q[`CTRL_USE_EN_BIT] |-> escalate)
    else $error("disabled handler not escalated");
  stack_exempt_a: assert property (stack_exempt |=> !report.escalated)
    else $error("bus stacking fault escalated");
  lock_entry_a: assert property (hard_now && exec_in.in_hard && !lock_q |=> lockup)
    else $error("lockup not entered");
  lock_hold_a: assert property (lockup && !nmi && !debug_halt |=> lockup)
    else $error("lockup left without cause");
  nmi_lock_a: assert property (lock_q && lock_nmi_q && !debug_halt |=> lockup)
    else $error("nmi released nmi lockup");
  sticky_a: assert property (use_q[`USE_UNDEF_BIT] && !(wr && hit_use) |=> use_q[`USE_UNDEF_BIT])
    else $error("flag dropped without clear");

  // ------------------------------------------------------------
  // per-flag, escalation and lockup checks
  // ------------------------------------------------------------
  instr_flag_a: assert property (
    fault_in.instr_access |=> mm_q[`MM_INSTR_BIT])
    else $error("instruction access flag missing");
  data_flag_a: assert property (
    fault_in.data_access |=> mm_q[`MM_DATA_BIT])
    else $error("data access flag missing");
  mm_stack_flag_a: assert property (
    fault_in.mm_stacking |=> mm_q[`MM_STACK_BIT])
    else $error("memory stacking flag missing");
  mm_unstack_flag_a: assert property (
    fault_in.mm_unstacking |=> mm_q[`MM_UNSTACK_BIT])
    else $error("memory unstacking flag missing");
  mm_lazy_flag_a: assert property (
    fault_in.mm_lazy_fp && HAS_FPU |=> mm_q[`MM_LAZY_BIT])
    else $error("memory lazy flag missing");
  bus_stack_flag_a: assert property (
    fault_in.bus_stacking |=> bus_q[`BUS_STACK_BIT])
    else $error("bus stacking flag missing");
  bus_unstack_flag_a: assert property (
    fault_in.bus_unstacking |=> bus_q[`BUS_UNSTACK_BIT])
    else $error("bus unstacking flag missing");
  prefetch_flag_a: assert property (
    fault_in.prefetch |=> bus_q[`BUS_PREFETCH_BIT])
    else $error("prefetch flag missing");
  bus_lazy_flag_a: assert property (
    fault_in.bus_lazy_fp && HAS_FPU |=> bus_q[`BUS_LAZY_BIT])
    else $error("bus lazy flag missing");
  inexact_flag_a: assert property (
    fault_in.data_bus_inexact |=> bus_q[`BUS_INEXACT_BIT])
    else $error("inexact bus flag missing");
  coproc_flag_a: assert property (
    fault_in.coprocessor |=> use_q[`USE_COPROC_BIT])
    else $error("coprocessor flag missing");
  undef_flag_a: assert property (
    fault_in.undefined |=> use_q[`USE_UNDEF_BIT])
    else $error("undefined flag missing");
  return_flag_a: assert property (
    fault_in.bad_return_code |=> use_q[`USE_RETURN_BIT])
    else $error("return code flag missing");
  state_flag_a: assert property (
    fault_in.foreign_set || fault_in.continuation_return |=> use_q[`USE_STATE_BIT])
    else $error("invalid state flag missing");
  unalign_flag_a: assert property (
    fault_in.unaligned |=> use_q[`USE_UNALIGN_BIT])
    else $error("unaligned flag missing");
  lazy_absent_a: assert property (
    !HAS_FPU |-> !mm_q[`MM_LAZY_BIT] && !bus_q[`BUS_LAZY_BIT])
    else $error("lazy flag set without fpu");

  // escalation seen from the report, not from the internal decision
  same_kind_a: assert property (
    sel_use && exec_in.servicing_use |=> report.escalated)
    else $error("own handler fault not escalated");
  low_prio_a: assert property (
    sel_use && exec_in.in_handler && prio_use_q >= exec_in.exec_priority |=> report.escalated)
    else $error("low priority fault not escalated");
  hard_class_a: assert property (
    ev_vec && !lock_q && !exec_in.in_nmi && !exec_in.in_hard
      |=> report.take && report.cls == cls_hard)
    else $error("hard fault not reported first");
  mm_addr_a: assert property (
    fault_in.data_access |=> mm_addr_q == $past(fault_in.address))
    else $error("memory fault address not captured");
  bus_addr_a: assert property (
    fault_in.data_bus_exact |=> bus_addr_q == $past(fault_in.address))
    else $error("bus fault address not captured");
  nmi_release_a: assert property (
    lock_q && !lock_nmi_q && nmi |=> !lockup)
    else $error("nmi did not release lockup");
  halt_release_a: assert property (
    lock_q && debug_halt |=> !lockup)
    else $error("halt did not release lockup");
  nmi_origin_a: assert property (
    !lock_q && lock_entry && exec_in.in_nmi |=> lock_nmi_q)
    else $error("nmi origin of lockup not kept");

  esc_cover: cover property (escalate ##1 report.escalated);
  lock_cover: cover property (lockup ##1 !lockup);
  clear_cover: cover property (wr && hit_bus ##1 bus_q == `WORD_ZERO);
  nmi_lock_cover: cover property (lock_q && lock_nmi_q);
  exempt_cover: cover property (stack_exempt ##1 report.take);
endmodule

// ===== tb/fault_source.sv
// far-side model: pipeline and bus interface presenting fault events
`timescale 1ns/100ps
module fault_source (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       fire,
  input  wire fault_pkg::fault_event_type fire_event,
  input  wire fault_pkg::exec_state_type  fire_state,
  output fault_pkg::fault_event_type      fault_in,
  output fault_pkg::exec_state_type       exec_in
);
  import fault_pkg::*;
  logic [31:0] last_addr_q;
  // ------------------------------------------------------------
  // one event per request, execution state held until the next
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_in    <= '0;
      exec_in     <= '0;
      last_addr_q <= 32'h0000_0000;
    end else if (fire) begin
      fault_in    <= fire_event;
      exec_in     <= fire_state;
      last_addr_q <= fire_event.address;
    end else begin
      fault_in         <= '0;
      // idle address bus is not held, so a stale capture shows up
      fault_in.address <= ~last_addr_q;
    end
  end
endmodule

// ===== tb/fault_unit_test.sv
// self-checking bench of the fault unit fed by the far-side event source
`timescale 1ns/100ps
`include "fault_map.svh"
module fault_unit_test;
  import fault_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, nmi, debug_halt, fire, err, pready;
  logic             pslverr, lockup;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, a, seed;
  logic [7:0]       p;
  fault_event_type  fault_in, ev;
  exec_state_type   exec_in, st, s;
  fault_report_type report, report2;
  int               miscompares, total_checks, cycles;
  int               sbit [20] = '{0, 0, 1, 4, 3, 5, 4, 3, 0, 5, 1, 2, 1, 3, 0, 1, 1, 2, 8, 9};

  fault_source src (.pclk(pclk), .presetn(presetn), .fire(fire), .fire_event(ev),
    .fire_state(st), .fault_in(fault_in), .exec_in(exec_in));
  fault_unit #(.HAS_FPU(1'b1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_in(fault_in), .exec_in(exec_in), .nmi(nmi),
    .debug_halt(debug_halt), .report(report), .lockup(lockup));
  // second unit built without the fpu: only its take bit is judged, refused for lazy events and given for all others
  fault_unit #(.HAS_FPU(1'b0)) uut_nofpu (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .fault_in(fault_in), .exec_in(exec_in), .nmi(nmi),
    .debug_halt(debug_halt), .report(report2), .lockup());

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // expectations, bus cycles and comparisons
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic fault_class_type cls_of(input int k);
    if (k < 6) return cls_mem;
    if (k < 12) return cls_bus;
    if (k == 12) return cls_hard;
    return cls_use;
  endfunction
  function automatic logic [11:0] stat_of(input fault_class_type c);
    case (c)
      cls_mem: return `MM_STATUS_ADDR;
      cls_bus: return `BUS_STATUS_ADDR;
      cls_use: return `USE_STATUS_ADDR;
      default: return `HF_STATUS_ADDR;
    endcase
  endfunction
  function automatic logic [31:0] rep_of(input logic t, input fault_class_type c, input logic e);
    return {28'h0, t, c, e};
  endfunction
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait: only the bench timeout ends a stalled transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_check(input string name, input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0000_0000);
    check_word(name, exp, rd);
  endtask
  task automatic clear_all();
    for (int i = 0; i < 4; i++) apb(1'b1, stat_of(fault_class_type'(i)), 32'hffff_ffff);
  endtask
  task automatic shoot(input int k, input logic [31:0] ad, input logic en, input exec_state_type x);
    fault_event_type e;
    e = '0;
    e[52 - k] = 1'b1;
    e.entering_bus_handler = en;
    e.address = ad;
    @(posedge pclk);
    fire <= 1'b1;
    ev   <= e;
    st   <= x;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
  task automatic pulse(input logic n, input logic h);
    @(posedge pclk);
    nmi        <= n;
    debug_halt <= h;
    @(posedge pclk);
    nmi        <= 1'b0;
    debug_halt <= 1'b0;
    #1;
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h0000_001e;
    {miscompares, total_checks, cycles} = '0;
    {presetn, psel, penable, pwrite, nmi, debug_halt, fire} = '0;
    {paddr, pwdata, ev, st} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i <= 32; i += 4) rd_check("reset value", 12'(i), `WORD_ZERO);
    apb(1'b1, 12'h024, 32'hffff_ffff);
    apb(1'b0, 12'h024, 32'h0000_0000);
    check_word("unmapped data", 32'h0, rd);
    check_word("unmapped error", 32'h1, {31'h0, err});
    // handlers start disabled, so the first usage fault must escalate
    shoot(14, xorshift(), 1'b0, '0);
    check_word("disabled report", rep_of(1'b1, cls_hard, 1'b1), {28'h0, report});
    rd_check("forced flag", `HF_STATUS_ADDR, 32'h4000_0000);
    clear_all();
    p = 8'(xorshift() % 32'd254) + 8'h01;
    apb(1'b1, `CONTROL_ADDR, 32'h0000_0007);
    apb(1'b1, `PRIORITY_ADDR, {8'h0, p, p, p});
    rd_check("priority", `PRIORITY_ADDR, {8'h0, p, p, p});
    for (int k = 0; k < 20; k++) begin
      a = xorshift();
      shoot(k, a, 1'b0, '0);
      check_word("report", rep_of(1'b1, cls_of(k), 1'b0), {28'h0, report});
      check_word("no fpu take", {31'h0, k != 5 && k != 9}, {31'h0, report2.take});
      rd_check("status", stat_of(cls_of(k)), 32'h1 << sbit[k]);
      if (k inside {2, 3, 4}) rd_check("mm address", `MM_ADDRESS_ADDR, a);
      if (k inside {6, 7, 10}) rd_check("bus address", `BUS_ADDRESS_ADDR, a);
      clear_all();
      rd_check("cleared", stat_of(cls_of(k)), `WORD_ZERO);
    end
    // j0 fault below, j1 own kind at higher priority, j2 fault above, j3 equal
    for (int j = 0; j < 4; j++) begin
      s = '{1'b1, j == 0 ? p - 8'h01 : j == 3 ? p : p + 8'h01, 1'b0, 1'b0, j == 1, 1'b0, 1'b0};
      shoot(14, xorshift(), 1'b0, s);
      check_word("priority report", rep_of(1'b1, j != 2 ? cls_hard : cls_use, j != 2),
        {28'h0, report});
      rd_check("forced flag", `HF_STATUS_ADDR, j != 2 ? 32'h4000_0000 : 32'h0);
      clear_all();
    end
    shoot(6, xorshift(), 1'b1, '{1'b1, p, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    check_word("stack push report", rep_of(1'b1, cls_bus, 1'b0), {28'h0, report});
    apb(1'b1, `CONTROL_ADDR, 32'h0000_0000);
    for (int j = 0; j < 3; j++) begin
      s = '{1'b1, 8'h00, 1'b0, 1'b0, 1'b0, j == 1, j != 1};
      shoot(14, xorshift(), 1'b0, s);
      check_word("lockup", 32'h1, {31'h0, lockup});
      rd_check("lock state", `LOCK_STATE_ADDR, j == 1 ? 32'h3 : 32'h1);
      shoot(13, xorshift(), 1'b0, s);
      check_word("locked take", 32'h0, {31'h0, report.take});
      if (j == 2) break;
      pulse(1'b1, 1'b0);
      check_word("after nmi", {31'h0, j == 1}, {31'h0, lockup});
      pulse(1'b0, 1'b1);
      check_word("after halt", 32'h0, {31'h0, lockup});
    end
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    check_word("reset lockup", 32'h0, {31'h0, lockup});
    @(posedge pclk);
    presetn <= 1'b1;
    rd_check("lock after reset", `LOCK_STATE_ADDR, `WORD_ZERO);
    print_verdict();
  end
endmodule
